//--- core/aps_top.sv
// Design decision made here: register access over Wishbone.
`default_nettype none
module aps_top #(
	parameter int unsigned P_RST_HOLD   = aps_pkg::CYC_RST_HOLD,
	parameter int unsigned P_RST_SETTLE = aps_pkg::CYC_RST_SETTLE,
	parameter int unsigned P_TRIM_WAIT  = aps_pkg::CYC_TRIM_WAIT,
	parameter int unsigned P_GUARD      = aps_pkg::CYC_GUARD,
	parameter int unsigned P_SD_BASE    = aps_pkg::CYC_SD_BASE,
	parameter int unsigned P_LOSS       = aps_pkg::CYC_LOSS,
	parameter int unsigned P_SCALE_UNIT = aps_pkg::CYC_SCALE_UNIT,
	parameter logic [7:0]  P_VOL_LO     = 8'h00,
	parameter logic [7:0]  P_VOL_HI     = 8'h00,
	parameter logic [7:0]  P_MUTE_ADDR  = 8'h00
) (
	input  wire logic        clk_i,                    // Clock
	input  wire logic        rst_i,                    // Sync reset
	input  wire logic        wb_cyc_i,                 // Bus cycle
	input  wire logic        wb_stb_i,                 // Bus strobe
	input  wire logic        wb_we_i,                  // Bus write
	input  wire logic [7:0]  wb_adr_i,                 // Byte address
	input  wire logic [3:0]  wb_sel_i,                 // Byte lanes
	input  wire logic [31:0] wb_dat_i,                 // Write data
	output logic      [31:0] wb_dat_o,                 // Read data
	output logic             wb_ack_o,                 // Acknowledge
	output logic             dev_reset_n_o,            // Device reset
	output logic             power_down_n_o,           // Power-down pin
	output logic             line_driver_shutdown_n_o, // Line driver on
	output logic             dig_inputs_en_o,          // Inputs may be high
	output logic             devwr_req_o,              // Device write req
	output logic      [7:0]  devwr_addr_o,             // Device reg address
	output logic      [7:0]  devwr_data_o,             // Device reg data
	input  wire logic        devwr_ack_i               // Device write done
);
	import aps_pkg::*;

	aps_ctl_if  ctl ();
	aps_state_t state_q, state_d;
	logic       enter_q, enter_d;
	logic       pd_q, pd_d;
	logic       first_q, sent_q;
	logic       dw_req_q, dw_req_d;
	logic [7:0] dw_addr_q, dw_addr_d;
	logic [7:0] dw_data_q, dw_data_d;
	logic       rst_n_q, pdn_q, inen_q, ld_q, ref_q;
	logic       t_done, g_done;
	logic [31:0] t_val, wait_q, age_q, low_q;

	aps_wb_regs u_regs (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (wb_cyc_i),
		.stb_i (wb_stb_i),
		.we_i  (wb_we_i),
		.adr_i (wb_adr_i),
		.sel_i (wb_sel_i),
		.dat_i (wb_dat_i),
		.dat_o (wb_dat_o),
		.ack_o (wb_ack_o),
		.ctl   (ctl.slv)
	);

	// Effective start period and scaled waits
	wire [TMS_W-1:0] t_start = ctl.midz_en ? TMS_W'(MIDZ_START_MS)
		: ctl.t_start_ms;
	wire [TMS_W-1:0] t_sd = enter_d ? ctl.t_stop_ms : t_start;
	wire [31:0] sd_wait = P_SD_BASE + 32'(t_sd) * SCALE_TENTHS
		* P_SCALE_UNIT;
	wire [31:0] guard_val = P_GUARD + 32'(t_start) * SCALE_TENTHS
		* P_SCALE_UNIT;

	// Request decoding
	wire st_chg    = (state_d != state_q);
	wire idle      = ~dw_req_q;
	wire dw_done   = dw_req_q & devwr_ack_i;
	wire in_trim   = (state_q == ST_TRIM_WR);
	wire seq_issue = (in_trim | ((state_q == ST_SD_WR) & g_done))
		& idle & ~sent_q;
	wire vol_ok    = ((ctl.pt_addr >= P_VOL_LO) & (ctl.pt_addr <= P_VOL_HI))
		| (ctl.pt_addr == P_MUTE_ADDR);
	wire pt_ok     = (state_q == ST_SHUTDOWN)
		| ((state_q == ST_NORMAL) & vol_ok);
	wire pt_take   = ctl.pt_go & idle & pt_ok & ~ctl.cmd[CMD_LOSS];
	wire powered   = (state_q != ST_OFF) & (state_q != ST_LOSS_WAIT)
		& (state_q != ST_RST_ASSERT);
	wire arm_guard = in_trim & dw_done & ~first_q;
	wire t_load    = st_chg;

	assign ctl.state      = state_q;
	assign ctl.busy       = dw_req_q | ((state_q != ST_OFF)
		& (state_q != ST_SHUTDOWN) & (state_q != ST_NORMAL));
	assign ctl.guard_busy = ~g_done;
	assign ctl.refused    = ref_q;

	assign dev_reset_n_o            = rst_n_q;
	assign power_down_n_o           = pdn_q;
	assign dig_inputs_en_o          = inen_q;
	assign line_driver_shutdown_n_o = ld_q;
	assign devwr_req_o              = dw_req_q;
	assign devwr_addr_o             = dw_addr_q;
	assign devwr_data_o             = dw_data_q;

	aps_wait_timer #(.W(32)) u_seq_tmr (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.load_i (t_load),
		.val_i  (t_val),
		.done_o (t_done)
	);

	aps_wait_timer #(.W(32)) u_guard_tmr (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.load_i (arm_guard),
		.val_i  (guard_val),
		.done_o (g_done)
	);

	// Wait length for the state being entered
	always_comb begin
		unique case (state_d)
			ST_RST_LOW:    t_val = P_RST_HOLD;
			ST_RST_SETTLE: t_val = P_RST_SETTLE;
			ST_TRIM_WAIT:  t_val = P_TRIM_WAIT;
			ST_SD_WAIT:    t_val = sd_wait;
			ST_LOSS_WAIT:  t_val = P_LOSS;
			ST_RST_ASSERT: t_val = CYC_RST_INPUTS;
			default:       t_val = 32'h0000_0001;
		endcase
	end

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		enter_d = enter_q;
		pd_d    = pd_q;
		unique case (state_q)
			ST_OFF: begin
				if (ctl.cmd[CMD_PWRUP]) state_d = ST_RST_LOW;
			end
			ST_RST_LOW: begin
				if (t_done) state_d = ST_RST_SETTLE;
			end
			ST_RST_SETTLE: begin
				if (t_done) state_d = ST_TRIM_WR;
			end
			ST_TRIM_WR: begin
				if (dw_done) state_d = ST_TRIM_WAIT;
			end
			ST_TRIM_WAIT: begin
				if (t_done) state_d = ST_SHUTDOWN;
			end
			ST_SHUTDOWN: begin
				if (idle & ctl.cmd[CMD_EXIT]) begin
					state_d = ST_SD_WR;
					enter_d = 1'b0;
				end else if (idle & ctl.cmd[CMD_PWRDN]) begin
					state_d = ST_RST_ASSERT;
				end
			end
			ST_NORMAL: begin
				if (idle & (ctl.cmd[CMD_ENTER] | ctl.cmd[CMD_PWRDN])) begin
					state_d = ST_SD_WR;
					enter_d = 1'b1;
					pd_d    = ctl.cmd[CMD_PWRDN];
				end
			end
			ST_SD_WR: begin
				if (dw_done) state_d = ST_SD_WAIT;
			end
			ST_SD_WAIT: begin
				if (t_done) begin
					pd_d = 1'b0;
					if (!enter_q) state_d = ST_NORMAL;
					else if (pd_q) state_d = ST_RST_ASSERT;
					else state_d = ST_SHUTDOWN;
				end
			end
			ST_LOSS_WAIT: begin
				if (t_done) state_d = ST_RST_ASSERT;
			end
			ST_RST_ASSERT: begin
				if (t_done) state_d = ST_OFF;
			end
			default: state_d = ST_OFF;
		endcase
		if (ctl.cmd[CMD_LOSS] & powered) begin
			state_d = ST_LOSS_WAIT;
			pd_d    = 1'b0;
		end
	end

	// Device write request; dropped when the device loses power
	always_comb begin
		dw_req_d  = dw_req_q & ~dw_done;
		dw_addr_d = dw_addr_q;
		dw_data_d = dw_data_q;
		if (seq_issue) begin
			dw_req_d  = 1'b1;
			dw_addr_d = in_trim ? DEV_OSC_TRIM_ADDR : DEV_SD_CTRL_ADDR;
			dw_data_d = in_trim ? DEV_TRIM_VAL
				: (enter_q ? DEV_SD_ENTER_VAL : DEV_SD_EXIT_VAL);
		end else if (pt_take) begin
			dw_req_d  = 1'b1;
			dw_addr_d = ctl.pt_addr;
			dw_data_d = ctl.pt_data;
		end
		if ((state_d == ST_LOSS_WAIT) | (state_d == ST_RST_ASSERT)
			| (state_d == ST_OFF)) begin
			dw_req_d = 1'b0;
		end
	end

	// State and write registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q   <= ST_OFF;
			enter_q   <= 1'b0;
			pd_q      <= 1'b0;
			first_q   <= 1'b0;
			sent_q    <= 1'b0;
			dw_req_q  <= 1'b0;
			dw_addr_q <= 8'h00;
			dw_data_q <= 8'h00;
			ref_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			enter_q   <= enter_d;
			pd_q      <= pd_d;
			first_q   <= first_q | arm_guard;
			sent_q    <= ~st_chg & (sent_q | seq_issue);
			dw_req_q  <= dw_req_d;
			dw_addr_q <= dw_addr_d;
			dw_data_q <= dw_data_d;
			ref_q     <= (ctl.pt_go & ~pt_take) | ((|ctl.cmd) & ~st_chg);
		end
	end

	// Pin levels follow the state being entered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_n_q <= 1'b0;
			pdn_q   <= 1'b0;
			inen_q  <= 1'b0;
			ld_q    <= 1'b0;
		end else begin
			rst_n_q <= (state_d != ST_OFF) & (state_d != ST_RST_LOW)
				& (state_d != ST_RST_ASSERT);
			pdn_q   <= (state_d != ST_OFF) & (state_d != ST_LOSS_WAIT)
				& (state_d != ST_RST_ASSERT);
			inen_q  <= (state_d != ST_OFF);
			ld_q    <= ctl.ld_en & (state_d != ST_OFF)
				& (state_d != ST_RST_ASSERT);
		end
	end

	// Checking aids: cycles in state, reset-low time, wait loaded
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			age_q  <= 32'h0000_0000;
			low_q  <= 32'h0000_0000;
			wait_q <= 32'h0000_0000;
		end else begin
			age_q  <= st_chg ? 32'h0000_0000 : age_q + 32'h1;
			low_q  <= rst_n_q ? 32'h0000_0000 : low_q + 32'h1;
			if (t_load) wait_q <= t_val;
		end
	end

	// All checks run on the one clock and rest while reset is high
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_inputs_off: assert property (
		(state_q == ST_OFF) |-> !inen_q && !rst_n_q && !pdn_q)
		else $error("inputs driven while off");
	a_rst_hold: assert property (
		$rose(rst_n_q) |-> pdn_q && $past(low_q) + 1 >= P_RST_HOLD)
		else $error("reset released too early");
	a_trim_write: assert property (
		(seq_issue && in_trim) |=> devwr_req_o
		&& devwr_addr_o == DEV_OSC_TRIM_ADDR && devwr_data_o == DEV_TRIM_VAL)
		else $error("trim write wrong");
	a_wait_length: assert property (
		(st_chg && !ctl.cmd[CMD_LOSS] && (state_q == ST_TRIM_WAIT
		|| state_q == ST_RST_SETTLE || state_q == ST_SD_WAIT))
		|-> age_q + 1 >= wait_q)
		else $error("wait cut short");
	a_guard_hold: assert property (
		(state_q == ST_SD_WR && !g_done) |-> !seq_issue ##1 !devwr_req_o)
		else $error("shutdown change inside guard");
	a_enter_value: assert property (
		(seq_issue && state_q == ST_SD_WR)
		|=> devwr_addr_o == DEV_SD_CTRL_ADDR
		&& devwr_data_o == (enter_q ? DEV_SD_ENTER_VAL : DEV_SD_EXIT_VAL))
		else $error("shutdown write wrong");
	a_normal_filter: assert property (
		(state_q == ST_NORMAL && pt_take) |-> vol_ok)
		else $error("illegal access in normal operation");
	a_loss_pins: assert property (
		(state_q == ST_LOSS_WAIT && !st_chg) |=> !pdn_q && rst_n_q)
		else $error("loss pins wrong");
	a_inputs_late: assert property (
		$fell(inen_q) |-> $past(low_q) + 1 >= CYC_RST_INPUTS)
		else $error("inputs dropped before reset settled");
	a_ld_powered: assert property (
		ld_q |-> inen_q)
		else $error("line driver on while unpowered");

	c_reach_normal: cover property (
		$rose(state_q == ST_NORMAL));
	c_enter_sd: cover property (
		(state_q == ST_SD_WAIT && enter_q) ##1 (state_q == ST_SHUTDOWN));
	c_power_loss: cover property (
		(state_q == ST_LOSS_WAIT) ##1 (state_q == ST_RST_ASSERT));
endmodule
`default_nettype wire

//--- pkg/aps_pkg.sv
`default_nettype none
package aps_pkg;
	// Clock rate
	localparam int unsigned CLK_MHZ         = 250;
	// Waits in their own units
	localparam int unsigned T_RST_HOLD_US   = 100;
	localparam int unsigned T_RST_SETTLE_US = 13500;
	localparam int unsigned T_TRIM_WAIT_MS  = 50;
	localparam int unsigned T_GUARD_MS      = 240;
	localparam int unsigned T_SD_BASE_MS    = 1;
	localparam int unsigned T_LOSS_MS       = 2;
	localparam int unsigned T_RST_INPUTS_US = 2;
	localparam int unsigned MIDZ_START_MS   = 300;
	localparam int unsigned SCALE_TENTHS    = 13;
	localparam int unsigned T_SCALE_UNIT_US = 100;
	// Waits in clock cycles
	localparam int unsigned CYC_RST_HOLD    = T_RST_HOLD_US * CLK_MHZ;
	localparam int unsigned CYC_RST_SETTLE  = T_RST_SETTLE_US * CLK_MHZ;
	localparam int unsigned CYC_TRIM_WAIT   = T_TRIM_WAIT_MS * 1000 * CLK_MHZ;
	localparam int unsigned CYC_GUARD       = T_GUARD_MS * 1000 * CLK_MHZ;
	localparam int unsigned CYC_SD_BASE     = T_SD_BASE_MS * 1000 * CLK_MHZ;
	localparam int unsigned CYC_LOSS        = T_LOSS_MS * 1000 * CLK_MHZ;
	localparam int unsigned CYC_RST_INPUTS  = T_RST_INPUTS_US * CLK_MHZ;
	localparam int unsigned CYC_SCALE_UNIT  = T_SCALE_UNIT_US * CLK_MHZ;
	// Device registers and values
	localparam logic [7:0]  DEV_SD_CTRL_ADDR  = 8'h05;
	localparam logic [7:0]  DEV_OSC_TRIM_ADDR = 8'h1b;
	localparam logic [7:0]  DEV_PWM_PER_ADDR  = 8'h1a;
	localparam logic [7:0]  DEV_SD_ENTER_VAL  = 8'h40;
	localparam logic [7:0]  DEV_SD_EXIT_VAL   = 8'h00;
	localparam logic [7:0]  DEV_TRIM_VAL      = 8'h00;
	// Own register map, byte addresses
	localparam logic [7:0]  REG_CTRL  = 8'h00;
	localparam logic [7:0]  REG_CFG   = 8'h04;
	localparam logic [7:0]  REG_DEVWR = 8'h08;
	localparam logic [7:0]  REG_STAT  = 8'h0c;
	// Field positions
	localparam int unsigned CMD_PWRUP = 0;
	localparam int unsigned CMD_ENTER = 1;
	localparam int unsigned CMD_EXIT  = 2;
	localparam int unsigned CMD_PWRDN = 3;
	localparam int unsigned CMD_LOSS  = 4;
	localparam int unsigned CMD_W     = 5;
	localparam int unsigned CTRL_LD_BIT    = 8;
	localparam int unsigned TMS_W          = 10;
	localparam int unsigned CFG_START_LSB  = 0;
	localparam int unsigned CFG_STOP_LSB   = 16;
	localparam int unsigned CFG_MIDZ_BIT   = 31;
	localparam int unsigned DEVWR_ADDR_LSB = 8;
	localparam int unsigned STAT_BUSY_BIT  = 4;
	localparam int unsigned STAT_GUARD_BIT = 5;
	localparam int unsigned STAT_REF_BIT   = 6;
	// Reset values
	localparam logic [31:0] CFG_RST  = 32'h0000_0000;
	localparam logic        LD_RST   = 1'b0;
	// Sequencer states
	typedef enum logic [3:0] {
		ST_OFF        = 4'h0,
		ST_RST_LOW    = 4'h1,
		ST_RST_SETTLE = 4'h2,
		ST_TRIM_WR    = 4'h3,
		ST_TRIM_WAIT  = 4'h4,
		ST_SHUTDOWN   = 4'h5,
		ST_SD_WR      = 4'h6,
		ST_SD_WAIT    = 4'h7,
		ST_NORMAL     = 4'h8,
		ST_LOSS_WAIT  = 4'h9,
		ST_RST_ASSERT = 4'ha
	} aps_state_t;
endpackage
`default_nettype wire

//--- pkg/aps_ctl_if.sv
`default_nettype none
interface aps_ctl_if;
	import aps_pkg::*;
	logic [CMD_W-1:0] cmd;        // Command pulses
	logic             pt_go;      // Pass-through write pulse
	logic [7:0]       pt_addr;    // Pass-through device address
	logic [7:0]       pt_data;    // Pass-through device data
	logic [TMS_W-1:0] t_start_ms; // Programmed start period, ms
	logic [TMS_W-1:0] t_stop_ms;  // Programmed stop period, ms
	logic             midz_en;    // Mid-impedance ramp in use
	logic             ld_en;      // Line driver requested on
	aps_state_t       state;      // Sequencer state
	logic             busy;       // Sequence or write in progress
	logic             guard_busy; // Post-trim guard running
	logic             refused;    // Request refused pulse
	modport slv(output cmd, pt_go, pt_addr, pt_data, t_start_ms, t_stop_ms,
		midz_en, ld_en, input state, busy, guard_busy, refused);
	modport seq(input cmd, pt_go, pt_addr, pt_data, t_start_ms, t_stop_ms,
		midz_en, ld_en, output state, busy, guard_busy, refused);
endinterface
`default_nettype wire

//--- core/aps_wait_timer.sv
`default_nettype none
module aps_wait_timer #(
	parameter int unsigned W = 32
) (
	input  wire logic         clk_i,  // Clock
	input  wire logic         rst_i,  // Synchronous reset
	input  wire logic         load_i, // Start a wait
	input  wire logic [W-1:0] val_i,  // Wait length in cycles
	output logic              done_o  // Wait elapsed
);
	logic [W-1:0] cnt_q;

	// Idle when the count has run out
	assign done_o = (cnt_q == '0);

	// Down counter, reloadable at any time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (load_i) begin
			cnt_q <= val_i;
		end else if (!done_o) begin
			cnt_q <= cnt_q - W'(1);
		end
	end
endmodule
`default_nettype wire

//--- core/aps_wb_regs.sv
`default_nettype none
module aps_wb_regs (
	input  wire logic        clk_i,  // Clock
	input  wire logic        rst_i,  // Synchronous reset
	input  wire logic        cyc_i,  // Bus cycle
	input  wire logic        stb_i,  // Strobe
	input  wire logic        we_i,   // Write enable
	input  wire logic [7:0]  adr_i,  // Byte address
	input  wire logic [3:0]  sel_i,  // Byte lanes
	input  wire logic [31:0] dat_i,  // Write data
	output logic      [31:0] dat_o,  // Read data
	output logic             ack_o,  // Acknowledge
	aps_ctl_if.slv           ctl     // Sequencer side
);
	import aps_pkg::*;

	logic        ack_q;
	logic [31:0] dat_q;
	logic [31:0] cfg_q;
	logic [CMD_W-1:0] cmd_q;
	logic        ld_q;
	logic        pt_go_q;
	logic [15:0] pt_q;
	logic        ref_q;
	logic [31:0] rdata;

	// Decode: full-word writes only, one access per ack
	wire req      = cyc_i & stb_i & ~ack_q;
	wire wr       = req & we_i & (sel_i == 4'hf);
	wire hit_ctrl = (adr_i == REG_CTRL);
	wire hit_cfg  = (adr_i == REG_CFG);
	wire hit_dw   = (adr_i == REG_DEVWR);
	wire hit_stat = (adr_i == REG_STAT);
	wire ref_clr  = wr & hit_stat & dat_i[STAT_REF_BIT];

	// Read mux, unmapped reads return zero
	assign rdata = hit_ctrl ? {23'h0, ld_q, 8'h00} :
		hit_cfg ? cfg_q :
		hit_dw ? {16'h0, pt_q} :
		hit_stat ? {25'h0, ref_q, ctl.guard_busy, ctl.busy, ctl.state} :
		32'h0000_0000;

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign ctl.cmd = cmd_q;
	assign ctl.ld_en = ld_q;
	assign ctl.pt_go = pt_go_q;
	assign ctl.pt_addr = pt_q[DEVWR_ADDR_LSB +: 8];
	assign ctl.pt_data = pt_q[7:0];
	assign ctl.t_start_ms = cfg_q[CFG_START_LSB +: TMS_W];
	assign ctl.t_stop_ms = cfg_q[CFG_STOP_LSB +: TMS_W];
	assign ctl.midz_en = cfg_q[CFG_MIDZ_BIT];

	// Bus answer and command pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q   <= 1'b0;
			dat_q   <= 32'h0000_0000;
			cmd_q   <= '0;
			pt_go_q <= 1'b0;
		end else begin
			ack_q   <= req;
			dat_q   <= req ? rdata : 32'h0000_0000;
			cmd_q   <= (wr & hit_ctrl) ? dat_i[CMD_W-1:0] : '0;
			pt_go_q <= wr & hit_dw;
		end
	end

	// Stored settings; a new refusal wins over its clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= CFG_RST;
			ld_q  <= LD_RST;
			pt_q  <= 16'h0000;
			ref_q <= 1'b0;
		end else begin
			if (wr & hit_cfg) cfg_q <= dat_i;
			if (wr & hit_ctrl) ld_q <= dat_i[CTRL_LD_BIT];
			if (wr & hit_dw) pt_q <= dat_i[15:0];
			ref_q <= ctl.refused | (ref_q & ~ref_clr);
		end
	end
endmodule
`default_nettype wire

//--- sim/aps_dev_model.sv
`default_nettype none
// Amplifier register port: answers each write after a chosen delay
module aps_dev_model (
	input  wire logic       clk_i,     // Clock
	input  wire logic       rst_n_i,   // Device reset pin
	input  wire logic       ld_sd_n_i, // Line driver pin, own path
	input  wire logic       req_i,     // Write request
	input  wire logic [7:0] addr_i,    // Register address
	input  wire logic [7:0] data_i,    // Register data
	input  wire logic [2:0] dly_i,     // Answer delay, cycles
	output logic            ack_o,     // Write done pulse
	output logic            ld_on_o,   // Line driver running
	output logic      [7:0] sd_val_o   // Shutdown register content
);
	timeunit 1ns;
	timeprecision 1ps;
	import aps_pkg::*;
	logic [7:0] regs_q [0:255]; // Register file
	logic [2:0] cnt_q;          // Delay count
	// Line driver follows its pin alone, not the speaker state
	assign ld_on_o = ld_sd_n_i;
	// Shutdown register as the amplifier last took it
	assign sd_val_o = regs_q[DEV_SD_CTRL_ADDR];
	// Every write is answered once its delay count reaches dly_i
	always_ff @(posedge clk_i) begin
		ack_o <= req_i && !ack_o && cnt_q >= dly_i;
		cnt_q <= (req_i && !ack_o) ? cnt_q + 3'h1 : 3'h0;
	end
	// Shutdown, period and trim registers take the written byte
	always_ff @(posedge clk_i) begin
		if (rst_n_i && req_i && ack_o) begin
			regs_q[addr_i] <= data_i;
		end
	end
endmodule
`default_nettype wire

//--- sim/aps_top_tb_top.sv
`default_nettype none
module aps_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import aps_pkg::*;
	localparam int SD = 4; // Shortened base shutdown wait
	localparam int ST = 5; // Start period, ms
	localparam int SP = 3; // Stop period, ms
	localparam int RH = 4;  // Shortened reset hold
	localparam int RS = 8;  // Shortened reset settle
	localparam int TW = 8;  // Shortened trim wait
	localparam int GD = 20; // Shortened guard base
	localparam int LS = 4;  // Shortened loss wait
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hf;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rd_q;
	logic        ack, rstn, power_down_n, ldn, en, req, wack, dld;
	logic [7:0]  waddr, wdata, dsd;
	logic [2:0]  dly = 3'h0;
	logic [63:0] rq[$];
	logic [15:0] dq[$];
	int          n_errors = 0;
	int          samples_checked = 0;
	int          n_cyc = 0;
	int          t_pdn_r, t_pdn_f, t_rstn_r, t_rstn_f, t_en_f, t_req, t_ack;
	int          t_trim;
	aps_top #(.P_RST_HOLD(RH), .P_RST_SETTLE(RS), .P_TRIM_WAIT(TW),
		.P_GUARD(GD), .P_SD_BASE(SD), .P_LOSS(LS), .P_SCALE_UNIT(1),
		.P_VOL_LO(8'h07), .P_VOL_HI(8'h0a), .P_MUTE_ADDR(8'h06)) u_aps_top (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .dev_reset_n_o(rstn),
		.power_down_n_o(power_down_n), .line_driver_shutdown_n_o(ldn),
		.dig_inputs_en_o(en), .devwr_req_o(req), .devwr_addr_o(waddr),
		.devwr_data_o(wdata), .devwr_ack_i(wack));
	aps_dev_model u_aps_dev_model (.clk_i(clk_i), .rst_n_i(rstn),
		.ld_sd_n_i(ldn), .req_i(req), .addr_i(waddr), .data_i(wdata),
		.dly_i(dly), .ack_o(wack), .ld_on_o(dld), .sd_val_o(dsd));
	// Clock, 4 ns period
	always #2 clk_i = ~clk_i;
	task automatic fail(input string m);
		n_errors++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic chk_rd(input logic [63:0] e, input logic [31:0] g);
		samples_checked++;
		if ((g & e[63:32]) !== e[31:0]) fail($sformatf("read %h", g));
	endtask
	task automatic chk_wr(input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) fail($sformatf("dev write %h want %h", g, e));
	endtask
	task automatic chk_t(input int g, input int lo, input int hi);
		samples_checked++;
		if (g < lo || g > hi) fail($sformatf("gap %0d not %0d", g, lo));
	endtask
	task automatic chk_pin(input logic g, input logic e);
		samples_checked++;
		if (g !== e) fail("pin level");
	endtask
	task automatic report_and_stop();
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// One classic bus cycle, entered just after a rising edge
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'hf);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= a;
		dat <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (k >= 50) fail("no bus ack");
		rd_q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [63:0] e);
		rq.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic wait_st(input aps_state_t s);
		int k;
		k = 0;
		do begin
			wb(1'b0, REG_STAT, 32'h0);
			k++;
		end while (rd_q[3:0] !== s && k < 3000);
		if (k >= 3000) fail("state not reached");
	endtask
	// Device write through the pass-through register, random data
	task automatic dev(input logic [7:0] a, input logic ok);
		logic [7:0] d;
		d = 8'($urandom);
		if (ok) dq.push_back({a, d});
		wr(REG_DEVWR, {16'h0, a, d});
		repeat (3) @(posedge clk_i);
		while (req === 1'b1) @(posedge clk_i);
	endtask
	// Shutdown register command, then timed arrival in the next state
	task automatic sd(input int b, input logic [7:0] v, input aps_state_t s,
		input int lo);
		dq.push_back({DEV_SD_CTRL_ADDR, v});
		wr(REG_CTRL, 32'h1 << b);
		wait_st(s);
		chk_t(n_cyc - t_ack, lo, lo + 10);
	endtask
	task automatic power_up();
		dq.push_back({DEV_OSC_TRIM_ADDR, DEV_TRIM_VAL});
		wr(REG_CTRL, 32'h1 << CMD_PWRUP);
		wait_st(ST_SHUTDOWN);
		chk_t(t_rstn_r - t_pdn_r, RH, RH + 2);
		chk_t(t_req - t_rstn_r, RS, RS + 4);
		chk_t(n_cyc - t_ack, TW, TW + 10);
	endtask
	// Output watcher: edge times, and results against the oldest note
	always @(posedge clk_i) begin
		n_cyc <= n_cyc + 1;
		if ($rose(power_down_n)) t_pdn_r <= n_cyc;
		if ($fell(power_down_n)) t_pdn_f <= n_cyc;
		if ($rose(rstn)) t_rstn_r <= n_cyc;
		if ($fell(rstn)) t_rstn_f <= n_cyc;
		if ($fell(en)) t_en_f <= n_cyc;
		if ($rose(req)) t_req <= n_cyc;
		if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) begin
			chk_rd(rq.pop_front(), rdat);
		end
		if (req === 1'b1 && wack === 1'b1) begin
			t_ack <= n_cyc;
			dly <= 3'($urandom % 6);
			chk_wr(dq.size() > 0 ? dq.pop_front() : 16'hxxxx, {waddr, wdata});
		end
	end
	// Watchdog
	initial begin
		#200000;
		fail("timeout");
		report_and_stop();
	end
	// Main sequence
	initial begin
		void'($urandom(32'h149e3a7b));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_pin(en, 1'b0);
		rd(REG_STAT, {32'hffffffff, 32'h0});
		rd(8'h10, {32'hffffffff, 32'h0});
		wr(REG_CTRL, 32'h1 << CMD_EXIT);
		repeat (2) @(posedge clk_i);
		rd(REG_STAT, {32'h40, 32'h40});
		wr(REG_STAT, 32'h40);
		rd(REG_STAT, {32'h4f, 32'h0});
		wb(1'b1, REG_CFG, $urandom, 4'($urandom % 15));
		rd(REG_CFG, {32'hffffffff, 32'h0});
		$display("test reset done");
		wr(REG_CFG, {16'(SP), 16'(ST)});
		power_up();
		t_trim = t_req;
		dev(DEV_PWM_PER_ADDR, 1'b1);
		wr(REG_CTRL, 32'h100);
		repeat (2) @(posedge clk_i);
		chk_pin(ldn, 1'b1);
		chk_pin(dld, 1'b1);
		rd(REG_STAT, {32'hf, 32'h5});
		wr(REG_CTRL, 32'h0);
		repeat (2) @(posedge clk_i);
		chk_pin(ldn, 1'b0);
		sd(CMD_EXIT, DEV_SD_EXIT_VAL, ST_NORMAL, SD + 13 * ST);
		chk_t(t_req - t_trim, GD + 13 * ST, GD + 13 * ST + 25);
		$display("test power-up done");
		dev(8'h08, 1'b1);
		dev(8'h06, 1'b1);
		dev(DEV_PWM_PER_ADDR, 1'b0);
		rd(REG_STAT, {32'h4f, 32'h48});
		wr(REG_STAT, 32'h40);
		sd(CMD_ENTER, DEV_SD_ENTER_VAL, ST_SHUTDOWN, SD + 13 * SP);
		chk_wr({DEV_SD_CTRL_ADDR, DEV_SD_ENTER_VAL}, {DEV_SD_CTRL_ADDR, dsd});
		sd(CMD_EXIT, DEV_SD_EXIT_VAL, ST_NORMAL, SD + 13 * ST);
		chk_wr({DEV_SD_CTRL_ADDR, DEV_SD_EXIT_VAL}, {DEV_SD_CTRL_ADDR, dsd});
		sd(CMD_PWRDN, DEV_SD_ENTER_VAL, ST_OFF,
			SD + 13 * SP + CYC_RST_INPUTS);
		chk_t(t_en_f - t_rstn_f, CYC_RST_INPUTS, CYC_RST_INPUTS + 3);
		$display("test shutdown done");
		wr(REG_CFG, 32'h8000_0000 | {16'(SP), 16'(ST)});
		power_up();
		sd(CMD_EXIT, DEV_SD_EXIT_VAL, ST_NORMAL, SD + 13 * MIDZ_START_MS);
		wr(REG_CTRL, 32'h1 << CMD_LOSS);
		wait_st(ST_OFF);
		chk_t(t_rstn_f - t_pdn_f, LS, LS + 2);
		chk_t(t_en_f - t_rstn_f, CYC_RST_INPUTS, CYC_RST_INPUTS + 3);
		chk_pin(en, 1'b0);
		$display("test power loss done");
		report_and_stop();
	end
endmodule
`default_nettype wire
